// *** ppe_top.sv ***
// PCI parity checking, error reporting and interrupt line driving.
// Assumes all PCI inputs are synchronous to i_sys_clk and an APB master.
// How it works
// R01 - The interrupt line is open drain and stays low until software clears its source or its enable bit.
// R02 - The parity bit is compared against the bus group seen one clock earlier.
// R03 - Parity is good when the ones over data, command and parity bit are even.
// R04 - Address errors go to the system error line, data errors to the parity error line, special cycles excepted.
// R05 - The system error line is driven only when its command enable bit is set.
// R06 - Address parity uses the group at the first frame clock, and errors drive one clock after parity.
// R07 - Each address parity error pulls the system error line low for one clock.
// R08 - Signalling a system error sets a sticky status bit until cleared or reset.
// R09 - The parity error line is driven only while this device receives data.
// R10 - The parity error line is asserted only when its command enable bit is set.
// R11 - Every data parity error outside special cycles while this device receives sets the detected parity status bit regardless of enable.
// R12 - As master, a data parity error sets the reported bit only when enabled.
// R13 - The parity error line asserts two clocks after the failing transfer.
// R14 - The parity error line asserts for one clock per error.
// R15 - Data parity is checked only on clocks where both ready signals are active.
// R16 - Sticky status bits clear when software writes a one to them.
`timescale 1ns/1ps

module ppe_top (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    // PCI bus sampled levels
    input wire ppe_pkg::ppe_bus_t i_bus,
    input wire logic i_par,
    input wire logic i_is_target_wr,
    input wire logic i_is_master_rd,
    // PCI lines, open drain except the tri-state parity error line: output level and enable
    output logic o_serr_n,
    output logic o_serr_oe,
    output logic o_perr_n,
    output logic o_perr_oe,
    output logic o_inta_n,
    output logic o_inta_oe,
    // Level interrupt to the local system
    output logic o_irq
);

    logic [15:0] cmd_q;
    logic [15:0] stat_q;
    logic [ppe_pkg::PPE_IRQ_W-1:0] icsr_q;
    logic [ppe_pkg::PPE_IRQ_W-1:0] ien_q;
    logic swint_q;
    logic frame_prev_q;
    ppe_pkg::ppe_bus_t bus_q;
    logic addr_ph_q;
    logic data_ph_q;
    logic recv_q;
    logic master_q;
    logic special_q;
    logic addr_err;
    logic data_err;
    logic odd_par;
    logic wr_acc;
    logic [31:0] wmask;

    // APB access decode, zero wait states
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign wmask = i_pwdata;

    // R03 even parity over group plus bit
    // R02 delayed parity against stored group
    assign odd_par = ^{bus_q.ad, bus_q.cbe_n, i_par};
    // R06 address error one clock after frame start
    assign addr_err = addr_ph_q && odd_par;
    // R15 data check only on completed transfers
    assign data_err = data_ph_q && odd_par && !special_q;

    // Pipeline stage that captures the group for the next clock's parity
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            bus_q <= '0;
            frame_prev_q <= 1'b0;
            addr_ph_q <= 1'b0;
            data_ph_q <= 1'b0;
            recv_q <= 1'b0;
            master_q <= 1'b0;
        end else begin
            bus_q <= i_bus;
            frame_prev_q <= !i_bus.frame_n;
            // R06 first clock of frame is address phase
            addr_ph_q <= !i_bus.frame_n && !frame_prev_q;
            // R15 both ready signals active
            data_ph_q <= !i_bus.irdy_n && !i_bus.trdy_n;
            recv_q <= i_is_target_wr || i_is_master_rd;
            master_q <= i_is_master_rd;
        end
    end

    // Latch the command of each address phase to spot special cycles
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            special_q <= 1'b0;
        end else if (addr_ph_q) begin
            // R04 special cycles not reported on parity line
            special_q <= (~bus_q.cbe_n == ppe_pkg::PPE_CMD_SPECIAL);
        end
    end

    // System error line, one-clock low pulse
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_serr_n <= 1'b1;
            o_serr_oe <= 1'b0;
        end else begin
            // R05 gated by enable; R07 one clock only; R04 address errors
            o_serr_n <= !(addr_err && cmd_q[ppe_pkg::PPE_CMD_SERR_EN]);
            o_serr_oe <= addr_err && cmd_q[ppe_pkg::PPE_CMD_SERR_EN];
        end
    end

    // Parity error line, driven while receiving, low one clock per error
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_perr_n <= 1'b1;
            o_perr_oe <= 1'b0;
        end else begin
            // R09 out of tri-state only while receiving
            o_perr_oe <= recv_q;
            // R10 enable gate; R13 two clocks after; R14 one clock
            o_perr_n <= !(data_err && recv_q &&
                cmd_q[ppe_pkg::PPE_CMD_PERR_EN]);
        end
    end

    // Command register
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            cmd_q <= ppe_pkg::PPE_CMD_RST;
        end else if (wr_acc && i_paddr == ppe_pkg::PPE_CMD_ADDR) begin
            cmd_q <= i_pwdata[15:0];
        end
    end

    // Status register: hardware set wins over write-one clear
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            stat_q <= '0;
        end else begin
            // R16 write one to clear
            if (wr_acc && i_paddr == ppe_pkg::PPE_STAT_ADDR) begin
                stat_q <= stat_q & ~wmask[15:0];
            end
            // R08 system error sticky
            if (addr_err && cmd_q[ppe_pkg::PPE_CMD_SERR_EN]) begin
                stat_q[ppe_pkg::PPE_ST_SSE] <= 1'b1;
            end
            // R11 detected parity regardless of enable
            if (data_err && recv_q) begin
                stat_q[ppe_pkg::PPE_ST_DPE] <= 1'b1;
            end
            // R12 master reported only when enabled
            if (data_err && master_q && cmd_q[ppe_pkg::PPE_CMD_PERR_EN]) begin
                stat_q[ppe_pkg::PPE_ST_DPR] <= 1'b1;
            end
        end
    end

    // Interrupt status, enable and software source
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            icsr_q <= '0;
            ien_q <= '0;
            swint_q <= 1'b0;
        end else begin
            if (wr_acc && i_paddr == ppe_pkg::PPE_IEN_ADDR) begin
                ien_q <= i_pwdata[ppe_pkg::PPE_IRQ_W-1:0];
            end
            if (wr_acc && i_paddr == ppe_pkg::PPE_CTRL_ADDR) begin
                swint_q <= i_pwdata[ppe_pkg::PPE_CTRL_SWINT];
            end
            // R16 clear register, set wins below
            if (wr_acc && i_paddr == ppe_pkg::PPE_ICLR_ADDR) begin
                icsr_q <= icsr_q & ~i_pwdata[ppe_pkg::PPE_IRQ_W-1:0];
            end
            if (addr_err && cmd_q[ppe_pkg::PPE_CMD_SERR_EN]) begin
                icsr_q[ppe_pkg::PPE_IRQ_SERR] <= 1'b1;
            end
            if (data_err && recv_q) begin
                icsr_q[ppe_pkg::PPE_IRQ_PERR] <= 1'b1;
            end
            if (swint_q) begin
                icsr_q[ppe_pkg::PPE_IRQ_SW] <= 1'b1;
            end
        end
    end

    // Interrupt outputs, held until the source bit or its enable bit is cleared
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_inta_n <= 1'b1;
            o_inta_oe <= 1'b0;
            o_irq <= 1'b0;
        end else begin
            // R01 open drain, held until cleared
            o_inta_oe <= |(icsr_q & ien_q);
            o_inta_n <= !(|(icsr_q & ien_q));
            o_irq <= |(icsr_q & ien_q);
        end
    end

    // APB answer: ready in the access cycle, read data registered
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pready <= 1'b0;
            o_prdata <= '0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= i_psel && !i_penable;
            o_pslverr <= 1'b0;
            o_prdata <= '0;
            if (i_psel && !i_penable) begin
                unique case (i_paddr)
                    ppe_pkg::PPE_CMD_ADDR: o_prdata <= {16'h0000, cmd_q};
                    ppe_pkg::PPE_STAT_ADDR: o_prdata <= {16'h0000, stat_q};
                    ppe_pkg::PPE_ICSR_ADDR:
                        o_prdata <= {29'h0, icsr_q};
                    ppe_pkg::PPE_IEN_ADDR: o_prdata <= {29'h0, ien_q};
                    ppe_pkg::PPE_ICLR_ADDR: o_prdata <= 32'h0;
                    ppe_pkg::PPE_CTRL_ADDR: o_prdata <= {31'h0, swint_q};
                    default: o_pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule // ppe_top

// *** ppe_pkg.sv ***
// Package for the PCI parity error and interrupt block.
// Assumes an APB master on the system clock; no other users.
package ppe_pkg;

    // Register byte addresses
    localparam logic [7:0] PPE_CMD_ADDR = 8'h00;
    localparam logic [7:0] PPE_STAT_ADDR = 8'h04;
    localparam logic [7:0] PPE_ICSR_ADDR = 8'h08;
    localparam logic [7:0] PPE_IEN_ADDR = 8'h0c;
    localparam logic [7:0] PPE_ICLR_ADDR = 8'h10;
    localparam logic [7:0] PPE_CTRL_ADDR = 8'h14;

    // Command register fields
    localparam int PPE_CMD_PERR_EN = 6;
    localparam int PPE_CMD_SERR_EN = 8;

    // Status register fields
    localparam int PPE_ST_DPR = 8;
    localparam int PPE_ST_SSE = 14;
    localparam int PPE_ST_DPE = 15;

    // Interrupt status and control fields
    localparam int PPE_IRQ_SERR = 0;
    localparam int PPE_IRQ_PERR = 1;
    localparam int PPE_IRQ_SW = 2;
    localparam int PPE_IRQ_W = 3;

    // Control register fields
    localparam int PPE_CTRL_SWINT = 0;

    // Command register reset value and an error data word
    localparam logic [15:0] PPE_CMD_RST = 16'h0000;
    localparam logic [31:0] PPE_ERR_DATA = 32'hdeadbeef;

    // PCI sampled bus group, raw pin levels (active-low kept as pins)
    typedef struct packed {
        logic [31:0] ad;
        logic [3:0] cbe_n;
        logic frame_n;
        logic irdy_n;
        logic trdy_n;
    } ppe_bus_t;

    // Special cycle command code
    localparam logic [3:0] PPE_CMD_SPECIAL = 4'h1;

endpackage

// *** ppe_pci_agent.sv ***
// Model of the other PCI agents: drives the bus group and parity pin.
// Assumes the bench hands it each next group and a corrupt flag.
`timescale 1ns/1ps
module ppe_pci_agent (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Next group from the bench
    input wire ppe_pkg::ppe_bus_t i_nxt,
    input wire logic i_bad,
    // Bus pins
    output ppe_pkg::ppe_bus_t o_bus,
    output logic o_par
);
    logic bad_q;
    // Launch group; released AD lines show the inverse of the last value
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_bus <= '1;
            bad_q <= 1'b0;
        end else begin
            o_bus <= i_nxt;
            if (i_nxt.frame_n && i_nxt.irdy_n) begin
                o_bus.ad <= ~o_bus.ad;
            end
            bad_q <= i_bad;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        o_par <= ^{o_bus.ad, o_bus.cbe_n} ^ bad_q;
    end
endmodule // ppe_pci_agent

// *** ppe_checker.sv ***
// Checker for the parity error block, on the top module's ports.
// Assumes bus samples are raw pin levels on the system clock.
`timescale 1ns/1ps
module ppe_checker (
    // Clock, reset and APB
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic o_pready,
    // PCI side
    input wire ppe_pkg::ppe_bus_t i_bus,
    input wire logic i_par,
    input wire logic i_is_target_wr,
    input wire logic i_is_master_rd,
    input wire logic o_serr_n,
    input wire logic o_serr_oe,
    input wire logic o_perr_n,
    input wire logic o_perr_oe,
    input wire logic o_inta_n,
    input wire logic o_inta_oe,
    input wire logic o_irq
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    ppe_pkg::ppe_bus_t bus_q;
    logic frame_q;
    logic odd, addr_err, data_err, wr_acc, rx;
    // Previous group and the frame level before it
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            bus_q <= '1;
            frame_q <= 1'b1;
        end else begin
            bus_q <= i_bus;
            frame_q <= bus_q.frame_n;
        end
    end
    // Error causes from last group and this parity bit
    assign odd = ^{bus_q.ad, bus_q.cbe_n, i_par};
    assign addr_err = odd && frame_q && !bus_q.frame_n;
    assign data_err = odd && !bus_q.irdy_n && !bus_q.trdy_n;
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign rx = i_is_target_wr || i_is_master_rd;
    property p_serr_cause;
        o_serr_oe |-> $past(addr_err);
    endproperty
    a_serr_cause: assert property (p_serr_cause)
        else $error("serr without address error");
    property p_serr_one;
        o_serr_oe |=> !o_serr_oe;
    endproperty
    a_serr_one: assert property (p_serr_one)
        else $error("serr longer than one clock");
    property p_serr_lvl;
        o_serr_n == !o_serr_oe;
    endproperty
    a_serr_lvl: assert property (p_serr_lvl)
        else $error("serr level and enable disagree");
    property p_perr_cause;
        !o_perr_n |-> o_perr_oe && $past(data_err);
    endproperty
    a_perr_cause: assert property (p_perr_cause)
        else $error("perr without data error");
    property p_perr_oe;
        o_perr_oe |-> $past(rx, 2);
    endproperty
    a_perr_oe: assert property (p_perr_oe)
        else $error("perr driven while not receiving");
    property p_int_pin;
        (o_inta_oe == !o_inta_n) && (o_irq == o_inta_oe);
    endproperty
    a_int_pin: assert property (p_int_pin)
        else $error("interrupt pin and level differ");
    property p_int_hold;
        $fell(o_irq) |-> $past(wr_acc, 1) || $past(wr_acc, 2);
    endproperty
    a_int_hold: assert property (p_int_hold)
        else $error("interrupt dropped without a write");
    property p_ready;
        o_pready |-> $past(i_psel) && !$past(i_penable);
    endproperty
    a_ready: assert property (p_ready)
        else $error("pready outside first access cycle");
endmodule // ppe_checker
bind ppe_top ppe_checker u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .o_pready(o_pready), .i_bus(i_bus), .i_par(i_par),
    .i_is_target_wr(i_is_target_wr), .i_is_master_rd(i_is_master_rd),
    .o_serr_n(o_serr_n), .o_serr_oe(o_serr_oe), .o_perr_n(o_perr_n),
    .o_perr_oe(o_perr_oe), .o_inta_n(o_inta_n), .o_inta_oe(o_inta_oe),
    .o_irq(o_irq));

// *** pci_parity_error_and_interrupt_tb.sv ***
// Bench: APB master, PCI agent and a counting model of reports.
// Assumes one 20 MHz clock and an active high reset.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
    n_fail++; $display("BAD %0t mismatch", $time); end end
module pci_parity_error_and_interrupt_tb;
    logic i_sys_clk = 1'b0;
    logic i_reset = 1'b1;
    logic psel, pen, pwr, pready, slverr, bad, par, tw, mr, er;
    logic serr_n, serr_oe, perr_n, perr_oe, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, exp_st;
    ppe_pkg::ppe_bus_t nxt, bus;
    int n_fail = 0, checks_done = 0, n_serr = 0, n_perr = 0;
    int exp_serr = 0, exp_perr = 0, seed = 32'h9a3ff808;
    always #25 i_sys_clk = ~i_sys_clk;
    ppe_pci_agent u_agent (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
        .i_nxt(nxt), .i_bad(bad), .o_bus(bus), .o_par(par));
    ppe_top u_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_pready(pready), .o_prdata(prdata), .o_pslverr(slverr),
        .i_bus(bus), .i_par(par), .i_is_target_wr(tw), .i_is_master_rd(mr),
        .o_serr_n(serr_n), .o_serr_oe(serr_oe), .o_perr_n(perr_n),
        .o_perr_oe(perr_oe), .o_inta_n(), .o_inta_oe(), .o_irq(irq));
    // Count low clocks on the pulled-up system error and parity error lines
    always @(posedge i_sys_clk) begin
        if (serr_oe === 1'b1 && serr_n === 1'b0) n_serr++;
        if (perr_oe === 1'b1 && perr_n === 1'b0) n_perr++;
    end
    task automatic close_out;
        if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int n = 0;
        @(posedge i_sys_clk);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge i_sys_clk);
        pen <= 1'b1;
        do begin @(posedge i_sys_clk); n++; end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin n_fail++; close_out; end
        rd = prdata;
        er = slverr;
        {psel, pen} <= 2'b00;
    endtask
    // Address phase then one data phase, each with its own parity flag
    task automatic txn(input logic ba, input logic bd, input logic m);
        @(posedge i_sys_clk);
        {tw, mr, bad} <= {!m, m, ba};
        nxt <= {$random(seed), 4'h7, 3'b011};
        @(posedge i_sys_clk);
        nxt <= {$random(seed), 4'h0, 3'b100};
        bad <= bd;
        @(posedge i_sys_clk);
        nxt <= '1;
        bad <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
        {tw, mr} <= 2'b00;
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge i_sys_clk);
        `CHK(irq, e)
    endtask
    initial begin
        logic pe, se, m;
        {psel, pen, pwr, paddr, pwdata, bad, tw, mr} = '0;
        nxt = '1;
        repeat (8) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            {se, pe} = 2'(i);
            m = pe ^ se;
            apb(1, ppe_pkg::PPE_CMD_ADDR, {se, 1'b0, pe, 6'h0});
            txn(1, 1, m);
            exp_serr += se;
            exp_perr += pe;
            `CHK(n_serr, exp_serr)
            `CHK(n_perr, exp_perr)
            exp_st = {16'h0, 1'b1, se, 5'h0, pe & m, 8'h0};
            apb(0, ppe_pkg::PPE_STAT_ADDR, 0);
            `CHK(rd, exp_st)
            apb(1, ppe_pkg::PPE_STAT_ADDR, -1);
            apb(0, ppe_pkg::PPE_STAT_ADDR, 0);
            `CHK(rd, 32'h0)
        end
        txn(0, 0, 0);
        `CHK(n_serr + n_perr, exp_serr + exp_perr)
        irq_is(0);
        apb(1, ppe_pkg::PPE_IEN_ADDR, 3);
        irq_is(1);
        apb(0, ppe_pkg::PPE_ICSR_ADDR, 0);
        `CHK(rd[2:0], 3'h3)
        apb(1, ppe_pkg::PPE_IEN_ADDR, 0);
        irq_is(0);
        apb(1, ppe_pkg::PPE_IEN_ADDR, 3);
        irq_is(1);
        apb(1, ppe_pkg::PPE_ICLR_ADDR, 3);
        irq_is(0);
        apb(1, ppe_pkg::PPE_CTRL_ADDR, 1);
        apb(1, ppe_pkg::PPE_IEN_ADDR, 4);
        irq_is(1);
        apb(1, ppe_pkg::PPE_CTRL_ADDR, 0);
        apb(1, ppe_pkg::PPE_ICLR_ADDR, 4);
        irq_is(0);
        apb(0, 8'h18, 0);
        `CHK({er, rd}, 33'h100000000)
        close_out;
    end
    // Bound on the whole run
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        n_fail++;
        close_out;
    end
endmodule // pci_parity_error_and_interrupt_tb
